// [shared/tcc_pkg.sv]
// Constants and types shared by the timer capture and clear control block.
// Contract
// R1: Captured value holds until capture clear written.
// R2: Later events never overwrite an unacknowledged capture.
// R3: Clear bit 1 clears capture flag; zero ignored.
// R4: Clear bit 0 clears timeout flag; zero ignored.
// R5: Control bit 15 bypasses tick synchronisation stages.
// R6: Bypass with divide-by-one uses terminal count zero.
// R7: No bypass with divide-by-one uses count three.
// R8: Bit 14 event resets counter and prescaler; the code also requires bit 13 to be set.
// R9: Event reset serves PWM demodulation when enabled.
// R10: Bit 13 enables copying counter on events.
// R11: Bit 7 restarts counter on timeout clear write.
// R12: Capture flag raised and held until cleared.
package tcc_pkg;

	localparam int COUNT_W   = 16;
	localparam int PRE_W     = 8;
	localparam int EVT_SEL_W = 6;
	localparam int ADDR_W    = 8;

	localparam logic [7:0] ADDR_CAPTURED_COUNT      = 8'h00;
	localparam logic [7:0] ADDR_INTERRUPT_CLEAR     = 8'h04;
	localparam logic [7:0] ADDR_TIMER_CONTROL       = 8'h08;
	localparam logic [7:0] ADDR_EVENT_SOURCE_SELECT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STATUS          = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE          = 8'h14;
	localparam logic [7:0] ADDR_CURRENT_COUNT       = 8'h18;
	localparam logic [7:0] ADDR_LOAD_VALUE          = 8'h1c;

	localparam int CTL_SYNC_BYPASS     = 15;
	localparam int CTL_EVT_RST_EN      = 14;
	localparam int CTL_EVT_CAP_EN      = 13;
	localparam int CTL_RELOAD_ON_CLEAR = 7;
	localparam int CTL_ENABLE          = 4;
	localparam int CTL_MODE            = 3;
	localparam int CTL_UP              = 2;
	localparam int CTL_PRE_LO          = 0;

	localparam int CLR_CAPTURE_BIT = 1;
	localparam int CLR_TIMEOUT_BIT = 0;

	localparam logic [15:0] CTL_RESET = 16'h0008;
	localparam logic [15:0] CTL_WMASK = 16'he0ff;

	localparam logic [7:0] PRE_TC_BYPASS = 8'h00;
	localparam logic [7:0] PRE_TC_DIV4   = 8'h03;
	localparam logic [7:0] PRE_TC_DIV16  = 8'h0f;
	localparam logic [7:0] PRE_TC_DIV256 = 8'hff;

	typedef enum logic [1:0] {
		TCC_PRE_DIV1   = 2'b00,
		TCC_PRE_DIV16  = 2'b01,
		TCC_PRE_DIV256 = 2'b10,
		TCC_PRE_DIVMAX = 2'b11
	} tcc_pre_e;

	typedef enum logic {
		TCC_BUS_IDLE = 1'b0,
		TCC_BUS_ACK  = 1'b1
	} tcc_bus_e;

endpackage

// [shared/tcc_cnt_if.sv]
// Interface that carries control and results between the register block and the counter.
`timescale 1ns/100ps
`default_nettype none
interface tcc_cnt_if #(parameter int COUNT_W = 16, parameter int PRE_W = 8);
	logic               enable;
	logic               countUp;
	logic               periodic;
	logic               tick;
	logic               restart;
	logic [COUNT_W-1:0] loadValue;
	logic [PRE_W-1:0]   termCount;
	logic [COUNT_W-1:0] count;
	logic               timeout;

	modport ctl (output enable, countUp, periodic, tick, restart, loadValue, termCount,
		input count, timeout);
	modport cnt (input enable, countUp, periodic, tick, restart, loadValue, termCount,
		output count, timeout);
endinterface
`default_nettype wire

// [verilog/tcc_counter.sv]
// Prescaler and up/down counter of the timer.
`timescale 1ns/100ps
`default_nettype none
module tcc_counter #(
	parameter int COUNT_W = 16,
	parameter int PRE_W   = 8
)
(
	input wire logic clk,
	input wire logic rst,
	tcc_cnt_if.cnt   cif
);
	import tcc_pkg::*;

	logic [PRE_W-1:0]   preReg;
	logic [COUNT_W-1:0] countReg;
	logic [COUNT_W-1:0] startVal;
	logic               timeoutReg;
	logic               atEnd;
	logic               preWrap;

	always_comb
	begin
		startVal = cif.periodic ? cif.loadValue : (cif.countUp ? '0 : '1);
		atEnd    = cif.countUp ? (countReg == '1) : (countReg == '0);
		// A terminal count lowered below the running prescale value must still wrap at once.
		preWrap  = cif.tick && (preReg >= cif.termCount);
	end

	// The prescaler restarts with the counter so a restart always begins a full period.
	always_ff @(posedge clk)
	begin
		if (rst || !cif.enable || cif.restart)
			preReg <= '0; // R8
		else if (preWrap)
			preReg <= '0; // R6
		else if (cif.tick)
			preReg <= PRE_W'(preReg + 1'b1); // R7
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			countReg <= '0;
		else if (!cif.enable || cif.restart)
			countReg <= startVal; // R8
		else if (preWrap && atEnd)
			countReg <= startVal;
		else if (preWrap && cif.countUp)
			countReg <= COUNT_W'(countReg + 1'b1);
		else if (preWrap)
			countReg <= COUNT_W'(countReg - 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			timeoutReg <= 1'b0;
		else
			timeoutReg <= cif.enable && !cif.restart && preWrap && atEnd;
	end

	assign cif.count   = countReg;
	assign cif.timeout = timeoutReg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_div1_every_tick;
		cif.enable && cif.tick && cif.termCount == '0 && !cif.restart && !atEnd && cif.countUp
			|=> countReg == COUNT_W'($past(countReg) + 1'b1);
	endproperty
	a_div1_every_tick: assert property (p_div1_every_tick) // R6
		else $error("Divide-by-one tick did not advance the counter.");

	property p_restart_clears;
		cif.restart && cif.enable |=> preReg == '0 && countReg == $past(startVal);
	endproperty
	a_restart_clears: assert property (p_restart_clears) // R8
		else $error("Restart did not reset counter and prescaler.");
endmodule
`default_nettype wire

// [verilog/tcc_timer_capture.sv]
// Wishbone register block with capture, interrupt clear and control of the timer.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_capture #(
	parameter int EVT_N = 40
)
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [tcc_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	input  wire logic                  srcTick,
	input  wire logic [EVT_N-1:0]      evtIn,
	output logic                       irq
);
	import tcc_pkg::*;

	tcc_bus_e                busState;
	logic                    req;
	logic                    wrEn;
	logic [31:0]             rdData;
	logic [15:0]             ctlReg;
	logic [EVT_SEL_W-1:0]    evtSelReg;
	logic [1:0]              irqEnReg;
	logic [COUNT_W-1:0]      loadReg;
	logic [COUNT_W-1:0]      capReg;
	logic                    capFlag;
	logic                    toFlag;
	logic                    tickS1;
	logic                    tickS2;
	logic                    timerTick;
	logic                    evtLevel;
	logic                    evtPrev;
	logic                    evtFire;
	logic                    clrCap;
	logic                    clrTo;
	logic                    capTake;
	logic                    syncBypass;
	logic                    evtCapEn;
	logic                    evtRstEn;
	logic                    reloadOnClear;
	tcc_pre_e                preSel;
	logic [PRE_W-1:0]        termCount;
	logic [COUNT_W-1:0]      restartVal;

	tcc_cnt_if #(.COUNT_W(COUNT_W), .PRE_W(PRE_W)) cif ();

	tcc_counter #(
		.COUNT_W (COUNT_W),
		.PRE_W   (PRE_W)
	) u_counter (
		.clk (clk),
		.rst (rst),
		.cif (cif)
	);

	function automatic logic [15:0] mergeLanes(
		input logic [15:0] oldVal,
		input logic [31:0] wData,
		input logic [3:0]  sel
	);
		logic [15:0] merged;
		merged = oldVal;
		if (sel[0])
			merged[7:0] = wData[7:0];
		if (sel[1])
			merged[15:8] = wData[15:8];
		return merged;
	endfunction

	assign syncBypass    = ctlReg[CTL_SYNC_BYPASS];
	assign evtRstEn      = ctlReg[CTL_EVT_RST_EN];
	assign evtCapEn      = ctlReg[CTL_EVT_CAP_EN];
	assign reloadOnClear = ctlReg[CTL_RELOAD_ON_CLEAR];
	assign preSel        = tcc_pre_e'(ctlReg[CTL_PRE_LO +: 2]);

	// Bus slave: one wait state, so read data is registered and writes land on the ack edge.
	assign req = cyc_i && stb_i;

	always_ff @(posedge clk)
	begin
		if (rst)
			busState <= TCC_BUS_IDLE;
		else
			case (busState)
				TCC_BUS_IDLE:
					if (req)
						busState <= TCC_BUS_ACK;
				TCC_BUS_ACK:
					busState <= TCC_BUS_IDLE;
				default:
					busState <= TCC_BUS_IDLE;
			endcase
	end

	assign ack_o = (busState == TCC_BUS_ACK);
	assign wrEn  = ack_o && req && we_i;

	always_comb
	begin
		rdData = 32'h00000000;
		case (adr_i)
			ADDR_CAPTURED_COUNT:
				rdData = {16'h0000, capReg};
			ADDR_TIMER_CONTROL:
				rdData = {16'h0000, ctlReg};
			ADDR_EVENT_SOURCE_SELECT:
				rdData = {{(32 - EVT_SEL_W){1'b0}}, evtSelReg};
			ADDR_IRQ_STATUS:
				rdData = {30'h0, capFlag, toFlag};
			ADDR_IRQ_ENABLE:
				rdData = {30'h0, irqEnReg};
			ADDR_CURRENT_COUNT:
				rdData = {16'h0000, cif.count};
			ADDR_LOAD_VALUE:
				rdData = {16'h0000, loadReg};
			default:
				rdData = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			dat_o <= 32'h00000000;
		else if (busState == TCC_BUS_IDLE && req && !we_i)
			dat_o <= rdData;
	end

	// Writable registers.
	always_ff @(posedge clk)
	begin
		if (rst)
			ctlReg <= CTL_RESET;
		else if (wrEn && adr_i == ADDR_TIMER_CONTROL)
			ctlReg <= mergeLanes(ctlReg, dat_i, sel_i) & CTL_WMASK;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			evtSelReg <= '0;
		else if (wrEn && adr_i == ADDR_EVENT_SOURCE_SELECT && sel_i[0])
			evtSelReg <= dat_i[EVT_SEL_W-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			irqEnReg <= 2'h0;
		else if (wrEn && adr_i == ADDR_IRQ_ENABLE && sel_i[0])
			irqEnReg <= dat_i[1:0];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			loadReg <= '0;
		else if (wrEn && adr_i == ADDR_LOAD_VALUE)
			loadReg <= mergeLanes(loadReg, dat_i, sel_i);
	end

	// Clear strobes: only a one in the bit acts.
	assign clrCap = wrEn && adr_i == ADDR_INTERRUPT_CLEAR && sel_i[0]
		&& dat_i[CLR_CAPTURE_BIT]; // R3
	assign clrTo  = wrEn && adr_i == ADDR_INTERRUPT_CLEAR && sel_i[0]
		&& dat_i[CLR_TIMEOUT_BIT]; // R4

	// Tick synchronisation; the bypass saves two cycles of latency but is safe only when
	// the source tick already belongs to this clock.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tickS1 <= 1'b0;
			tickS2 <= 1'b0;
		end
		else
		begin
			tickS1 <= srcTick;
			tickS2 <= tickS1;
		end
	end

	assign timerTick = syncBypass ? srcTick : tickS2; // R5

	always_comb
	begin
		case (preSel)
			TCC_PRE_DIV1:
				termCount = syncBypass ? PRE_TC_BYPASS : PRE_TC_DIV4; // R6 R7
			TCC_PRE_DIV16:
				termCount = PRE_TC_DIV16;
			TCC_PRE_DIV256:
				termCount = PRE_TC_DIV256;
			default:
				termCount = PRE_TC_DIV256;
		endcase
	end

	// Event source selection and rising-edge detection.
	assign evtLevel = (int'(evtSelReg) < EVT_N) ? evtIn[evtSelReg] : 1'b0;

	always_ff @(posedge clk)
	begin
		if (rst)
			evtPrev <= 1'b0;
		else
			evtPrev <= evtLevel;
	end

	assign evtFire = evtLevel && !evtPrev;

	// A clear in the same cycle frees the holding register, so that event is not lost.
	assign capTake = evtCapEn && evtFire && (!capFlag || clrCap); // R10 R2

	always_ff @(posedge clk)
	begin
		if (rst)
			capReg <= '0;
		else if (capTake)
			capReg <= cif.count; // R1 R10
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			capFlag <= 1'b0;
		else if (capTake)
			capFlag <= 1'b1; // R12
		else if (clrCap)
			capFlag <= 1'b0; // R3
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			toFlag <= 1'b0;
		else if (cif.timeout)
			toFlag <= 1'b1;
		else if (clrTo)
			toFlag <= 1'b0; // R4
	end

	assign irq = |({capFlag, toFlag} & irqEnReg);

	// Counter hookup.
	assign cif.enable    = ctlReg[CTL_ENABLE];
	assign cif.countUp   = ctlReg[CTL_UP];
	assign cif.periodic  = ctlReg[CTL_MODE];
	assign cif.tick      = timerTick;
	assign cif.loadValue = loadReg;
	assign cif.termCount = termCount;
	assign cif.restart   = (evtRstEn && evtCapEn && evtFire) // R8 R9
		|| (reloadOnClear && clrTo); // R11
	assign restartVal    = cif.periodic ? loadReg : (cif.countUp ? '0 : '1);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_pending;
		capFlag && !clrCap;
	endsequence

	sequence s_fresh_event;
		evtCapEn && evtFire && !capFlag;
	endsequence

	property p_cap_hold;
		s_pending |=> $stable(capReg) && capFlag;
	endproperty
	a_cap_hold: assert property (p_cap_hold) // R1
		else $error("Captured value changed before it was cleared.");

	property p_cap_no_overwrite;
		s_pending and (evtFire && evtCapEn) |=> capReg == $past(capReg);
	endproperty
	a_cap_no_overwrite: assert property (p_cap_no_overwrite) // R2
		else $error("Held capture overwritten by a later event.");

	property p_cap_value;
		s_fresh_event |=> capReg == $past(cif.count) && capFlag;
	endproperty
	a_cap_value: assert property (p_cap_value) // R10
		else $error("Event did not capture the counter value.");

	property p_cap_disabled;
		!evtCapEn && !capFlag |=> !capFlag;
	endproperty
	a_cap_disabled: assert property (p_cap_disabled) // R10
		else $error("Capture happened with capture disabled.");

	property p_clr_cap;
		clrCap && !capTake |=> !capFlag ##1 (!capFlag || $past(capTake));
	endproperty
	a_clr_cap: assert property (p_clr_cap) // R3
		else $error("Capture flag not cleared by a one.");

	property p_clr_zero;
		wrEn && adr_i == ADDR_INTERRUPT_CLEAR && !dat_i[CLR_CAPTURE_BIT] && capFlag
			|=> capFlag;
	endproperty
	a_clr_zero: assert property (p_clr_zero) // R3
		else $error("Writing zero cleared the capture flag.");

	property p_clr_to;
		clrTo && !cif.timeout |=> !toFlag;
	endproperty
	a_clr_to: assert property (p_clr_to) // R4
		else $error("Timeout flag not cleared by a one.");

	property p_to_keep;
		toFlag && !clrTo |=> toFlag;
	endproperty
	a_to_keep: assert property (p_to_keep) // R4
		else $error("Timeout flag dropped without a clear.");

	sequence s_slow_tick;
		(srcTick && !syncBypass) ##1 !syncBypass ##1 !syncBypass;
	endsequence

	property p_sync_delay;
		s_slow_tick |-> timerTick;
	endproperty
	a_sync_delay: assert property (p_sync_delay) // R5
		else $error("Synchronised tick not seen two cycles later.");

	property p_div4;
		!syncBypass && preSel == TCC_PRE_DIV1 |-> cif.termCount == PRE_TC_DIV4;
	endproperty
	a_div4: assert property (p_div4) // R7
		else $error("Divide-by-one without bypass is not divide by four.");

	property p_evt_restart;
		evtRstEn && evtCapEn && evtFire |-> cif.restart;
	endproperty
	a_evt_restart: assert property (p_evt_restart) // R8
		else $error("Selected event did not restart the counter.");

	property p_reload;
		reloadOnClear && clrTo && cif.enable |=> cif.count == $past(restartVal);
	endproperty
	a_reload: assert property (p_reload) // R11
		else $error("Timeout clear did not restart the counter.");

	property p_irq;
		capFlag && irqEnReg[1] |-> irq;
	endproperty
	a_irq: assert property (p_irq) // R12
		else $error("Enabled capture flag did not raise the interrupt.");
endmodule
`default_nettype wire

// [testbench/tb_timer_capture_clear_control.sv]
// Self-checking testbench for the timer capture and clear control block.
`timescale 1ns/100ps
`default_nettype none
module tb_timer_capture_clear_control;
	import tcc_pkg::*;

	logic        clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] datW;
	logic [31:0] datR;
	logic        ack;
	logic        srcTick;
	logic [39:0] evtIn;
	logic        irq;
	logic [31:0] rdVal;
	logic [31:0] cap0;
	int          numErrors;
	int          samplesChecked;

	tcc_timer_capture #(.EVT_N(40)) uut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
		.srcTick(srcTick), .evtIn(evtIn), .irq(irq));

	always #12.5 clk = ~clk;

	task automatic printVerdict();
		if (numErrors == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic cycle; ack and read data are taken at the rising edge that ends the ack cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		sel <= 4'h3;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			chk("ack", {31'h0, ack}, 32'h1);
		rdVal = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic evt(input int idx);
		@(posedge clk);
		evtIn[idx] <= 1'b1;
		@(posedge clk);
		evtIn[idx] <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Exactly n ticks are sampled; the tail lets the synchroniser stages drain.
	task automatic ticks(input int n);
		@(posedge clk);
		srcTick <= 1'b1;
		repeat (n) @(posedge clk);
		srcTick <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic irqIs(input logic exp);
		@(negedge clk);
		chk("irq", {31'h0, irq}, {31'h0, exp});
	endtask

	task automatic t_reset();
		rd(ADDR_TIMER_CONTROL);
		chk("ctl reset", rdVal, 32'h0008);
		rd(ADDR_IRQ_STATUS);
		chk("status reset", rdVal, 32'h0);
		rd(8'h20);
		chk("unmapped", rdVal, 32'h0);
		rd(ADDR_INTERRUPT_CLEAR);
		chk("clear reads", rdVal, 32'h0);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'hffff);
		rd(ADDR_TIMER_CONTROL);
		chk("ctl mask", rdVal, {16'h0, CTL_WMASK});
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h0008);
		irqIs(1'b0);
	endtask

	task automatic t_capture();
		wb(1'b1, ADDR_EVENT_SOURCE_SELECT, 32'h3);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'ha014);
		wb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
		ticks(5);
		rd(ADDR_CURRENT_COUNT);
		chk("count", rdVal, 32'h5);
		cap0 = 32'h5;
		evt(3);
		rd(ADDR_CAPTURED_COUNT);
		chk("capture", rdVal, cap0);
		rd(ADDR_IRQ_STATUS);
		chk("cap flag", rdVal, 32'h2);
		irqIs(1'b1);
		ticks(3);
		evt(3);
		rd(ADDR_CAPTURED_COUNT);
		chk("capture held", rdVal, cap0);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h0);
		rd(ADDR_IRQ_STATUS);
		chk("clear zero", rdVal, 32'h2);
		rd(ADDR_CAPTURED_COUNT);
		chk("capture kept", rdVal, cap0);
		wb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
		irqIs(1'b0);
		wb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h2);
		rd(ADDR_IRQ_STATUS);
		chk("cap cleared", rdVal, 32'h0);
		irqIs(1'b0);
		rd(ADDR_CURRENT_COUNT);
		chk("count", rdVal, 32'h8);
		cap0 = 32'h8;
		evt(3);
		rd(ADDR_CAPTURED_COUNT);
		chk("recapture", rdVal, cap0);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h8014);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h2);
		evt(3);
		rd(ADDR_IRQ_STATUS);
		chk("capture off", rdVal, 32'h0);
	endtask

	// The event reset zeroes both counter and prescaler, so tick counts come out exact.
	task automatic t_prescale();
		for (int b = 1; b >= 0; b--)
		begin
			wb(1'b1, ADDR_TIMER_CONTROL, (b != 0) ? 32'he014 : 32'h6014);
			ticks(6);
			evt(3);
			rd(ADDR_CURRENT_COUNT);
			chk("event reset", rdVal, 32'h0);
			ticks(16);
			rd(ADDR_CURRENT_COUNT);
			chk("prescale", rdVal, (b != 0) ? 32'h10 : 32'h4);
		end
		wb(1'b1, ADDR_TIMER_CONTROL, 32'he015);
		evt(3);
		ticks(32);
		rd(ADDR_CURRENT_COUNT);
		chk("div16", rdVal, 32'h2);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h2);
	endtask

	task automatic t_timeout();
		wb(1'b1, ADDR_LOAD_VALUE, 32'hfffe);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h800c);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h801c);
		wb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
		ticks(3);
		rd(ADDR_IRQ_STATUS);
		chk("timeout flag", rdVal, 32'h1);
		irqIs(1'b1);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h2);
		rd(ADDR_IRQ_STATUS);
		chk("timeout kept", rdVal, 32'h1);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h1);
		rd(ADDR_IRQ_STATUS);
		chk("timeout clear", rdVal, 32'h0);
		irqIs(1'b0);
	endtask

	task automatic t_reload();
		wb(1'b1, ADDR_LOAD_VALUE, 32'h1000);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h800c);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h801c);
		ticks(5);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h1);
		rd(ADDR_CURRENT_COUNT);
		chk("no reload", rdVal, 32'h1005);
		wb(1'b1, ADDR_TIMER_CONTROL, 32'h809c);
		wb(1'b1, ADDR_INTERRUPT_CLEAR, 32'h1);
		rd(ADDR_CURRENT_COUNT);
		chk("reload", rdVal, 32'h1000);
	endtask

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		datW = 32'h0;
		srcTick = 1'b0;
		evtIn = 40'h0;
		numErrors = 0;
		samplesChecked = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_capture();
		t_prescale();
		t_timeout();
		t_reload();
		printVerdict();
	end

	initial
	begin
		#(25 * 20000);
		numErrors++;
		printVerdict();
	end
endmodule
`default_nettype wire
